// ---- logic/cts_pkg.sv ----
`default_nettype none
package cts_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] TIMER_SOURCE_SELECT_OFS = 8'h00;
   localparam logic [7:0] PERIPH_IRQ_FLAGS_4_OFS = 8'h01;
   localparam logic [7:0] PERIPH_IRQ_ENABLES_4_OFS = 8'h02;
   localparam logic [3:0] CHAN_PAGE = 4'h1;
   localparam logic [1:0] CHANNEL_CONTROL_IDX = 2'h0;
   localparam logic [1:0] CAPTURE_INPUT_SELECT_IDX = 2'h1;
   localparam logic [1:0] CHANNEL_VALUE_LOW_IDX = 2'h2;
   localparam logic [1:0] CHANNEL_VALUE_HIGH_IDX = 2'h3;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CH1_TIMER_SEL_LSB = 0;
   localparam int CH2_TIMER_SEL_LSB = 2;
   localparam int CH3_TIMER_SEL_LSB = 4;
   localparam int CH4_TIMER_SEL_LSB = 6;
   localparam int CHAN_EN_BIT = 7;
   localparam int CHAN_OUT_BIT = 5;
   localparam int CHAN_FMT_BIT = 4;
   localparam int CHAN_MODE_LSB = 0;

   // ------------------------------------------------------------
   // reset values and masks
   // ------------------------------------------------------------
   localparam logic [1:0] TIMER_SEL_RST = 2'h1;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h9f;
   localparam logic [3:0] CAP_SEL_RST = 4'h0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] VALUE_RST = 16'h0000;

   // ------------------------------------------------------------
   // channel modes
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CC_LAST = 4'hb;
   localparam logic [3:0] MODE_PWM = 4'hf;

   // ------------------------------------------------------------
   // timer indices
   // ------------------------------------------------------------
   localparam logic [2:0] TIMER_ZERO = 3'h0;
   localparam logic [2:0] TIMER_ONE = 3'h1;
   localparam logic [2:0] TIMER_TWO = 3'h2;
   localparam logic [2:0] TIMER_THREE = 3'h3;
   localparam logic [2:0] TIMER_FOUR = 3'h4;
   localparam logic [2:0] TIMER_FIVE = 3'h5;
   localparam logic [2:0] TIMER_SIX = 3'h6;

   typedef struct packed {
      logic [7:0] sel;
      logic [3:0] flag;
      logic [3:0] ien;
      logic [3:0][7:0] ctl;
      logic [3:0][3:0] cap;
      logic [3:0][15:0] val;
      logic [3:0][15:0] cnt;
      logic [3:0] match;
      logic irq;
      logic [7:0] rdata;
   } cts_state_t;
endpackage
`default_nettype wire

// ---- logic/cts_route.sv ----
`timescale 1ns/1ps
`default_nettype none
module cts_route
(
   input wire logic [1:0] chan_timer_sel,
   input wire logic [3:0] chan_mode,
   input wire logic chan_en,
   output logic [2:0] timer_idx,
   output logic active
);
   // ------------------------------------------------------------
   // selector and mode to timer index
   // ------------------------------------------------------------
   always_comb
   begin
      timer_idx = cts_pkg::TIMER_ZERO;
      active = 1'b0;
      if (chan_en && chan_mode == cts_pkg::MODE_PWM)
      begin
         active = 1'b1;
         case (chan_timer_sel)
            2'h0: timer_idx = cts_pkg::TIMER_TWO;
            2'h1: timer_idx = cts_pkg::TIMER_TWO;
            2'h2: timer_idx = cts_pkg::TIMER_FOUR;
            2'h3: timer_idx = cts_pkg::TIMER_SIX;
            default: timer_idx = cts_pkg::TIMER_TWO;
         endcase
      end
      else if (chan_en && chan_mode != cts_pkg::MODE_OFF &&
               chan_mode <= cts_pkg::MODE_CC_LAST)
      begin
         active = 1'b1;
         case (chan_timer_sel)
            2'h0: timer_idx = cts_pkg::TIMER_ZERO;
            2'h1: timer_idx = cts_pkg::TIMER_ONE;
            2'h2: timer_idx = cts_pkg::TIMER_THREE;
            2'h3: timer_idx = cts_pkg::TIMER_FIVE;
            default: timer_idx = cts_pkg::TIMER_ZERO;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- logic/cts_top.sv ----
// Behaviour
// - bits 7:6 select channel 4 timer
// - bits 5:4 select channel 3 timer
// - bits 3:2 select channel 2 timer
// - bits 1:0 select channel 1 timer
// - every selector field resets to 01
// - code maps to timer per mode column
// - channel flags at bits 0-3
// - channel enables at bits 0-3, aligned
// - unimplemented bits ignore writes, read zero
// - mode picks column; 0000 turns channel off
// - event sets channel flag only when channel is enabled in modes 0001-1011 or 1111
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cts_top
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic [6:0][15:0] timer_count,
   input wire logic [6:0] timer_match,
   input wire logic [3:0] chan_event,
   input wire logic [3:0] chan_out,
   output logic [3:0][15:0] chan_count,
   output logic [3:0] chan_match,
   output logic [3:0][3:0] chan_mode,
   output logic [3:0] chan_fmt,
   output logic [3:0][3:0] chan_cap_sel,
   output logic [3:0][15:0] chan_value,
   output logic irq
);
   cts_pkg::cts_state_t s_q;
   cts_pkg::cts_state_t s_d;
   logic [3:0][1:0] sel_field;
   logic [3:0][2:0] timer_idx;
   logic [3:0] active;

   // ------------------------------------------------------------
   // selector fields per channel
   // ------------------------------------------------------------
   assign sel_field[0] = s_q.sel[cts_pkg::CH1_TIMER_SEL_LSB +: 2];
   assign sel_field[1] = s_q.sel[cts_pkg::CH2_TIMER_SEL_LSB +: 2];
   assign sel_field[2] = s_q.sel[cts_pkg::CH3_TIMER_SEL_LSB +: 2];
   assign sel_field[3] = s_q.sel[cts_pkg::CH4_TIMER_SEL_LSB +: 2];

   // ------------------------------------------------------------
   // per-channel routing
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_chan
         cts_route u_route
         (
            .chan_timer_sel(sel_field[g]),
            .chan_mode(s_q.ctl[g][cts_pkg::CHAN_MODE_LSB +: 4]),
            .chan_en(s_q.ctl[g][cts_pkg::CHAN_EN_BIT]),
            .timer_idx(timer_idx[g]),
            .active(active[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic [1:0] ch;
      logic [7:0] rd;
      logic [3:0] set;
      logic [3:0] clr;
      ch = addr[3:2];
      rd = 8'h00;
      set = 4'h0;
      clr = 4'h0;
      s_d = s_q;

      // routed count and match; off channels show zero
      for (int i = 0; i < 4; i++)
      begin
         if (active[i])
         begin
            s_d.cnt[i] = timer_count[timer_idx[i]];
            s_d.match[i] = timer_match[timer_idx[i]];
         end
         else
         begin
            s_d.cnt[i] = 16'h0000;
            s_d.match[i] = 1'b0;
         end
         set[i] = chan_event[i] & active[i];
      end

      // register writes
      if (wr_stb)
      begin
         if (addr == cts_pkg::TIMER_SOURCE_SELECT_OFS)
            s_d.sel = wdata;
         else if (addr == cts_pkg::PERIPH_IRQ_FLAGS_4_OFS)
            clr = ~wdata[3:0];
         else if (addr == cts_pkg::PERIPH_IRQ_ENABLES_4_OFS)
            s_d.ien = wdata[3:0];
         else if (addr[7:4] == cts_pkg::CHAN_PAGE)
         begin
            case (addr[1:0])
               cts_pkg::CHANNEL_CONTROL_IDX:
                  s_d.ctl[ch] = wdata & cts_pkg::CTRL_WRITE_MASK;
               cts_pkg::CAPTURE_INPUT_SELECT_IDX:
                  s_d.cap[ch] = wdata[3:0];
               cts_pkg::CHANNEL_VALUE_LOW_IDX:
                  s_d.val[ch][7:0] = wdata;
               cts_pkg::CHANNEL_VALUE_HIGH_IDX:
                  s_d.val[ch][15:8] = wdata;
               default: s_d.val[ch] = s_q.val[ch];
            endcase
         end
      end

      // register reads, one cycle later
      if (rd_stb)
      begin
         if (addr == cts_pkg::TIMER_SOURCE_SELECT_OFS)
            rd = s_q.sel;
         else if (addr == cts_pkg::PERIPH_IRQ_FLAGS_4_OFS)
         begin
            rd = {4'h0, s_q.flag};
            clr = 4'hf;
         end
         else if (addr == cts_pkg::PERIPH_IRQ_ENABLES_4_OFS)
            rd = {4'h0, s_q.ien};
         else if (addr[7:4] == cts_pkg::CHAN_PAGE)
         begin
            case (addr[1:0])
               cts_pkg::CHANNEL_CONTROL_IDX:
               begin
                  rd = s_q.ctl[ch];
                  rd[cts_pkg::CHAN_OUT_BIT] = chan_out[ch];
               end
               cts_pkg::CAPTURE_INPUT_SELECT_IDX:
                  rd = {4'h0, s_q.cap[ch]};
               cts_pkg::CHANNEL_VALUE_LOW_IDX:
                  rd = s_q.val[ch][7:0];
               cts_pkg::CHANNEL_VALUE_HIGH_IDX:
                  rd = s_q.val[ch][15:8];
               default: rd = 8'h00;
            endcase
         end
      end
      s_d.rdata = rd;

      // set wins over clear
      s_d.flag = (s_q.flag & ~clr) | set;
      s_d.irq = |(s_d.flag & s_d.ien);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
         s_q.sel <= {4{cts_pkg::TIMER_SEL_RST}};
         s_q.ctl <= {4{cts_pkg::CTRL_RST}};
         s_q.cap <= {4{cts_pkg::CAP_SEL_RST}};
         s_q.val <= {4{cts_pkg::VALUE_RST}};
      end
      else
         s_q <= s_d;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdata = s_q.rdata;
   assign chan_count = s_q.cnt;
   assign chan_match = s_q.match;
   assign irq = s_q.irq;
   assign chan_value = s_q.val;
   assign chan_cap_sel = s_q.cap;
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         chan_mode[i] = s_q.ctl[i][cts_pkg::CHAN_MODE_LSB +: 4];
         chan_fmt[i] = s_q.ctl[i][cts_pkg::CHAN_FMT_BIT];
      end
   end
endmodule
`default_nettype wire

// ---- testbench/cts_timers.sv ----
`timescale 1ns/1ps
`default_nettype none
module cts_timers
(
   input wire logic ref_clk,
   input wire logic rst_n,
   output logic [6:0][15:0] timer_count,
   output logic [6:0] timer_match
);
   // --------
   // timers, top nibble is the timer index plus one
   // --------
   logic [11:0] tick_q;
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         tick_q <= 12'h000;
      else
         tick_q <= tick_q + 12'h001;
   always_comb
      for (int i = 0; i < 7; i++)
      begin
         timer_count[i] = {4'(i + 1), tick_q};
         timer_match[i] = tick_q[2:0] == 3'(i);
      end
endmodule
`default_nettype wire

// ---- testbench/cts_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module cts_chk
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic [6:0][15:0] timer_count,
   input wire logic [3:0][15:0] chan_count,
   input wire logic [3:0] chan_match,
   input wire logic [3:0][3:0] chan_mode,
   input wire logic irq
);
   // --------
   // shadows
   // --------
   logic [7:0] sel_q;
   logic [3:0] ien_q;
   logic [3:0][15:0] exp_q;
   function automatic logic [2:0] tix(input logic [1:0] s, input logic [3:0] m);
      if (m == cts_pkg::MODE_PWM)
         return s[1] ? {s, 1'b0} : 3'h2;
      return s[1] ? {s, 1'b1} - 3'h2 : {1'b0, s};
   endfunction
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
      begin
         sel_q <= 8'h55;
         ien_q <= 4'h0;
      end
      else if (wr_stb && addr == 8'h00)
         sel_q <= wdata;
      else if (wr_stb && addr == 8'h02)
         ien_q <= wdata[3:0];
   // expected routed count, same edge as the design's register
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         exp_q <= '0;
      else
         for (int n = 0; n < 4; n++)
            exp_q[n] <= timer_count[tix(sel_q[2*n+:2], chan_mode[n])];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_ch1_route: assert property (chan_count[0] != 0
      |-> chan_count[0] == exp_q[0])
      else $error("ch1 route");
   a_ch2_route: assert property (chan_count[1] != 0
      |-> chan_count[1] == exp_q[1])
      else $error("ch2 route");
   a_ch3_route: assert property (chan_count[2] != 0
      |-> chan_count[2] == exp_q[2])
      else $error("ch3 route");
   a_ch4_route: assert property (chan_count[3] != 0
      |-> chan_count[3] == exp_q[3])
      else $error("ch4 route");
   a_mode_off: assert property (chan_mode[1] == 4'h0
      |=> chan_count[1] == 16'h0 && !chan_match[1]) else $error("off routes");
   a_sel_read: assert property (rd_stb && addr == 8'h00 |=> rdata == sel_q)
      else $error("selector read");
   a_unmapped_zero: assert property (rd_stb && addr == 8'h05 |=> rdata == 0)
      else $error("unmapped read");
   a_irq_upper: assert property (rd_stb && addr inside {1, 2}
      |=> rdata[7:4] == 4'h0) else $error("upper bits set");
   a_mask_quiet: assert property (ien_q == 4'h0 [*3] |-> !irq)
      else $error("masked irq");
   a_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
      else $error("rdata idle");
endmodule
`default_nettype wire

// ---- testbench/cts_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cts_top_tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [3:0] chan_event = 4'h0;
   logic [3:0] chan_out = 4'h1;
   logic [7:0] rdata;
   logic [6:0][15:0] timer_count;
   logic [6:0] timer_match;
   logic [3:0][15:0] chan_count;
   logic [3:0] chan_match;
   logic [3:0][3:0] chan_mode;
   logic [3:0] chan_fmt;
   logic [3:0][3:0] chan_cap_sel;
   logic [3:0][15:0] chan_value;
   logic irq;
   int errors = 0;
   int checks_done = 0;
   int cyc = 0;
   always #10 ref_clk = ~ref_clk;
   cts_top i_cts_top (.ref_clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb,
      .rdata, .timer_count, .timer_match, .chan_event, .chan_out,
      .chan_count, .chan_match, .chan_mode, .chan_fmt, .chan_cap_sel,
      .chan_value, .irq);
   cts_timers i_cts_timers (.ref_clk, .rst_n, .timer_count, .timer_match);
   // --------
   // tasks
   // --------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 chk(rdata, e);
      @(posedge ref_clk);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic t_route();
      logic [3:0] md [3] = '{4'h1, 4'hb, 4'hf};
      logic [3:0] tcc [4] = '{4'h1, 4'h2, 4'h4, 4'h6};
      logic [3:0] tpw [4] = '{4'h3, 4'h3, 4'h5, 4'h7};
      logic [7:0] s;
      logic [3:0] e;
      for (int j = 0; j < 3; j++)
      begin
         for (int n = 0; n < 4; n++)
            wr(8'h10 + 8'(4 * n), 8'h80 | md[j]);
         for (int c = 0; c < 4; c++)
         begin
            for (int n = 0; n < 4; n++)
               s[2*n+:2] = 2'(c + n);
            wr(8'h00, s);
            rc(8'h00, s);
            #1;
            for (int n = 0; n < 4; n++)
            begin
               e = md[j] == 4'hf ? tpw[(c+n)%4] : tcc[(c+n)%4];
               chk(chan_count[n][15:12], e);
               chk(chan_match[n], chan_count[n][2:0] == 3'(e - 4'h1));
            end
         end
      end
      $display("route test done");
   endtask
   task automatic t_irq();
      wr(8'h02, 8'hff);
      rc(8'h02, 8'h0f);
      chan_event <= 4'h5;
      @(posedge ref_clk);
      chan_event <= 4'h0;
      repeat (2) @(posedge ref_clk);
      #1 chk(irq, 1'b1);
      rc(8'h01, 8'h05);
      rc(8'h01, 8'h00);
      wr(8'h02, 8'h07);
      chan_event <= 4'h8;
      @(posedge ref_clk);
      chan_event <= 4'h0;
      repeat (2) @(posedge ref_clk);
      #1 chk(irq, 1'b0);
      rc(8'h01, 8'h08);
      $display("irq test done");
   endtask
   task automatic t_regs();
      wr(8'h05, 8'ha5);
      rc(8'h05, 8'h00);
      wr(8'h10, 8'hff);
      rc(8'h10, 8'hbf);
      wr(8'h11, 8'hff);
      rc(8'h11, 8'h0f);
      #1 chk(chan_fmt[0], 1'b1);
      chk(chan_cap_sel[0], 4'hf);
      wr(8'h12, 8'h34);
      wr(8'h13, 8'h12);
      #1 chk(chan_value[0], 16'h1234);
      wr(8'h10, 8'h80);
      wr(8'h14, 8'h0f);
      wr(8'h18, 8'h8c);
      #1 chk(chan_count[0], 16'h0);
      chk(chan_count[1], 16'h0);
      chk(chan_count[2], 16'h0);
      $display("register test done");
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         conclude();
      end
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rc(8'h00, 8'h55);
      t_route();
      t_irq();
      t_regs();
      conclude();
   end
endmodule
bind cts_top cts_chk i_cts_chk (.ref_clk, .rst_n, .addr, .wdata, .wr_stb,
   .rd_stb, .rdata, .timer_count, .chan_count, .chan_match, .chan_mode, .irq);
`default_nettype wire
